// [verif/lccc_cluster_group_test.sv]
// Self-checking bench for the cluster group
`timescale 1ns/1ps
module lccc_cluster_group_test;
  import lccc_pkg::*;
  localparam int CL = 4;
  localparam int N  = CL * CELLS_PER_CLUSTER;
  typedef struct {logic [9:0] a; logic [9:0] b; logic c; logic [10:0] s;} lccc_row_t;
  lccc_row_t rows [5] = '{'{10'h000, 10'h000, 1'b0, 11'h000}, '{10'h3ff, 10'h001, 1'b0, 11'h400},
    '{10'h3ff, 10'h3ff, 1'b1, 11'h7ff}, '{10'h155, 10'h2aa, 1'b1, 11'h400}, '{10'h1ff, 10'h000, 1'b1, 11'h200}};
  logic            sys_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic [N*4-1:0]  cell_data = '0;
  logic [N-1:0]    cell_out1_sel = '0, cell_out0, cell_out1;
  logic [CL-1:0]   cluster_clock_tick_a = '0, cluster_clock_tick_b = '0, cluster_clock_enable_a = '0;
  logic [CL-1:0]   cluster_clock_enable_b = '0, cluster_clear_a = '0, cluster_clear_b = '0, cluster_sync_clear = '0;
  logic [CL*2-1:0] cluster_clear_a_mode = '0, cluster_clear_b_mode = '0;
  logic [1:0]      carry_req = '0, chain_carry_in, chain_cascade_in, chain_carry_out, chain_cascade_out;
  int              err_count = 0;
  int              cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  lccc_fabric_model fab (.sys_clk, .carry_req, .chain_carry_in, .chain_cascade_in);
  lccc_cluster_group #(.CLUSTERS(CL)) DUT (
    .sys_clk, .sys_rst, .cell_data, .cell_lut_mask({N{ADDER_MASK}}), .cell_arith_mode({N{1'b1}}),
    .cell_cascade_mode({N{CASC_NONE}}), .cell_out0_sel({N{OUT_FROM_LUT}}), .cell_out1_sel,
    .cell_clock_sel({N{CLK_PAIR_A}}), .cluster_clock_tick_a, .cluster_clock_tick_b, .cluster_clock_enable_a,
    .cluster_clock_enable_b, .cluster_clear_a, .cluster_clear_b, .cluster_clear_a_mode, .cluster_clear_b_mode,
    .cluster_sync_clear, .chain_carry_in, .chain_cascade_in, .cell_out0, .cell_out1, .chain_carry_out,
    .chain_cascade_out);
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: cell output differs", $time);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    cell_out1_sel[0] = OUT_FROM_REG;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    #1;
    chk(cell_out1[0], Q_RESET);
    $display("test reset done");
    for (int i = 10; i < 20; i++) cell_data[4*i+1] = 1'b1;
    for (int i = 30; i < 40; i++) cell_data[4*i+1] = 1'b1;
    for (int r = 0; r < 5; r++) begin
      @(negedge sys_clk);
      for (int i = 0; i < 10; i++) cell_data[4*i+:2] = {rows[r].b[i], rows[r].a[i]};
      carry_req = {rows[r].c, rows[r].c};
      @(negedge sys_clk);
      #1;
      for (int i = 0; i < 10; i++) chk(cell_out0[i], rows[r].s[i]);
      chk(cell_out0[20], rows[r].s[10]);
      chk(cell_out0[10], !rows[r].c);
      chk(chain_carry_out[1], rows[r].c);
      chk(chain_cascade_out[1], !rows[r].c);
      chk(chain_carry_out[0], 1'b0);
    end
    $display("test adder done");
    @(negedge sys_clk);
    cell_data = '0;
    cell_data[0] = 1'b1;
    carry_req = '0;
    @(negedge sys_clk);
    cluster_clock_tick_b[0] = 1'b1;
    cluster_clock_enable_b[0] = 1'b1;
    @(negedge sys_clk);
    cluster_clock_tick_b[0] = 1'b0;
    cluster_clock_enable_b[0] = 1'b0;
    cluster_clock_tick_a[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b0);
    chk(cell_out0[0], 1'b1);
    @(negedge sys_clk);
    cluster_clock_enable_a[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b0);
    @(negedge sys_clk);
    cluster_clock_tick_a[0] = 1'b0;
    cell_data[0] = 1'b0;
    #1;
    chk(cell_out1[0], 1'b1);
    chk(cell_out0[0], 1'b0);
    $display("test register done");
    @(negedge sys_clk);
    cluster_clear_a_mode[1:0] = LINE_CLEAR;
    cluster_clear_a[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b0);
    @(negedge sys_clk);
    cluster_clear_a[0] = 1'b0;
    cluster_clear_b_mode[1:0] = LINE_PRESET;
    cluster_clear_b[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b1);
    @(negedge sys_clk);
    cluster_clear_b[0] = 1'b0;
    cell_data[0] = 1'b1;
    cluster_clock_tick_a[0] = 1'b1;
    cluster_sync_clear[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b1);
    @(negedge sys_clk);
    cluster_clock_tick_a[0] = 1'b0;
    cluster_sync_clear[0] = 1'b0;
    #1;
    chk(cell_out1[0], 1'b0);
    @(negedge sys_clk);
    cluster_clear_b_mode[1:0] = LINE_LOAD;
    cell_data[2] = 1'b1;
    cluster_clear_b[0] = 1'b1;
    #1;
    chk(cell_out1[0], 1'b1);
    $display("test cluster lines done");
    results();
  end
endmodule : lccc_cluster_group_test

// [verif/lccc_fabric_model.sv]
// Neighbouring fabric model that feeds the chain inputs of the cluster group
`timescale 1ns/1ps
module lccc_fabric_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] carry_req,
  output logic      [1:0] chain_carry_in,
  output logic      [1:0] chain_cascade_in
);
  initial chain_carry_in = 2'h0;
  initial chain_cascade_in = 2'h3;
  // Lower-order carry from outside changes only after a falling edge
  always @(negedge sys_clk) begin
    chain_carry_in <= carry_req;
  end
endmodule : lccc_fabric_model

// [verilog/lccc_cluster_group.sv]
// Group of logic cell clusters with carry chain, cascade chain and cluster controls
//
// Summary of operation
// - Each cell has two outputs, each chosen from table result or register.
// - One output may carry table result while the other carries it registered.
// - Incoming carry feeds both the cell table and the next carry stage.
// - Chains link cells 1 to 10 in order and continue across clusters.
// - Chain leaves a cluster's last cell for first cell two clusters on.
// - An n-bit adder uses n+1 cells; the extra cell exposes final carry.
// - Arithmetic table forms sum of two bits and carry; register optional.
// - Carry out comes from the upper table half and goes straight onward.
// - Cascade combines adjacent table results for wide functions.
// - The two cluster clear lines also serve as load and preset.
// - Two clock ticks per cluster, each paired with its own enable.
`timescale 1ns/1ps
module lccc_cluster_group
  import lccc_pkg::*;
#(
  parameter int CLUSTERS = CLUSTERS_DEF,
  parameter int CPC      = CELLS_PER_CLUSTER,
  parameter int N        = CLUSTERS * CPC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [N*4-1:0]        cell_data,
  input  wire logic [N*16-1:0]       cell_lut_mask,
  input  wire logic [N-1:0]          cell_arith_mode,
  input  wire logic [N*2-1:0]        cell_cascade_mode,
  input  wire logic [N-1:0]          cell_out0_sel,
  input  wire logic [N-1:0]          cell_out1_sel,
  input  wire logic [N-1:0]          cell_clock_sel,
  input  wire logic [CLUSTERS-1:0]   cluster_clock_tick_a,
  input  wire logic [CLUSTERS-1:0]   cluster_clock_tick_b,
  input  wire logic [CLUSTERS-1:0]   cluster_clock_enable_a,
  input  wire logic [CLUSTERS-1:0]   cluster_clock_enable_b,
  input  wire logic [CLUSTERS-1:0]   cluster_clear_a,
  input  wire logic [CLUSTERS-1:0]   cluster_clear_b,
  input  wire logic [CLUSTERS*2-1:0] cluster_clear_a_mode,
  input  wire logic [CLUSTERS*2-1:0] cluster_clear_b_mode,
  input  wire logic [CLUSTERS-1:0]   cluster_sync_clear,
  input  wire logic [1:0]            chain_carry_in,
  input  wire logic [1:0]            chain_cascade_in,
  output logic      [N-1:0]          cell_out0,
  output logic      [N-1:0]          cell_out1,
  output logic      [1:0]            chain_carry_out,
  output logic      [1:0]            chain_cascade_out
);

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Returns {force, value} for one cluster line in its chosen role
  function automatic logic [1:0] line_force(input logic active, input logic [1:0] mode, input logic load_val);
    logic [1:0] r;
    r = 2'h0;
    if (active) begin
      unique case (mode)
        LINE_CLEAR:  r = {1'b1, 1'b0};
        LINE_PRESET: r = {1'b1, 1'b1};
        LINE_LOAD:   r = {1'b1, load_val};
        LINE_OFF:    r = 2'h0;
      endcase
    end
    return r;
  endfunction : line_force

  // Cell i sits in cluster i/CPC at position i%CPC.
  // Even clusters form one chain and odd clusters the other.
  // Each chain enters a cluster at its first cell.
  // Per-cell chain and register nets
  logic [N-1:0] cin;
  logic [N-1:0] cout;
  logic [N-1:0] casc_in;
  logic [N-1:0] lut_res;
  logic [N-1:0] q;
  logic [N-1:0] q_eff;
  logic [N-1:0] next_q;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cell
      localparam int K = gi / CPC;
      localparam int J = gi % CPC;
      logic [3:0]          din;
      logic [LUT_BITS-1:0] mask;
      logic [2:0]          ar_idx;
      logic                lut_norm;
      logic                sum_bit;
      logic                carry_bit;
      logic                lut_raw;
      logic [1:0]          cmode;
      logic [1:0]          frc_a;
      logic [1:0]          frc_b;
      logic                force_on;
      logic                force_val;
      logic                tick;

      assign din  = cell_data[gi*LUT_INPUTS +: LUT_INPUTS];
      assign mask = cell_lut_mask[gi*LUT_BITS +: LUT_BITS];

      // Chain entry: in order inside a cluster, skipping one cluster between clusters
      if (J != 0) begin : g_inner
        assign cin[gi]     = cout[gi-1];
        assign casc_in[gi] = lut_res[gi-1];
      end else if (K < CHAIN_SKIP) begin : g_head
        assign cin[gi]     = chain_carry_in[K];
        assign casc_in[gi] = chain_cascade_in[K];
      end else begin : g_skip
        assign cin[gi]     = cout[gi-CPC-1];
        assign casc_in[gi] = lut_res[gi-CPC-1];
      end

      // Lower half forms the sum, upper half the carry
      assign ar_idx    = {cin[gi], din[1], din[0]};
      assign lut_norm  = mask[din];
      assign sum_bit   = mask[{1'b0, ar_idx}];
      assign carry_bit = mask[ARITH_HALF + 32'(ar_idx)];
      assign cout[gi]  = cell_arith_mode[gi] & carry_bit;
      assign lut_raw   = cell_arith_mode[gi] ? sum_bit : lut_norm;

      assign cmode = cell_cascade_mode[gi*2 +: 2];
      assign lut_res[gi] = (cmode == CASC_AND) ? (lut_raw & casc_in[gi]) :
                           (cmode == CASC_OR)  ? (lut_raw | casc_in[gi]) : lut_raw;

      // Cluster lines override the register at once and while held
      assign frc_a     = line_force(cluster_clear_a[K], cluster_clear_a_mode[K*2 +: 2], din[2]);
      assign frc_b     = line_force(cluster_clear_b[K], cluster_clear_b_mode[K*2 +: 2], din[2]);
      assign force_on  = frc_a[1] | frc_b[1];
      assign force_val = frc_a[1] ? frc_a[0] : frc_b[0];
      assign q_eff[gi] = force_on ? force_val : q[gi];

      // A cell follows one clock pair; a tick never uses the other pair's enable
      assign tick = (cell_clock_sel[gi] == CLK_PAIR_B) ?
                    (cluster_clock_tick_b[K] & cluster_clock_enable_b[K]) :
                    (cluster_clock_tick_a[K] & cluster_clock_enable_a[K]);
      // Line override first, then enabled tick, then sync clear over table result
      assign next_q[gi] = force_on ? force_val :
                          !tick ? q[gi] :
                          cluster_sync_clear[K] ? Q_RESET : lut_res[gi];

      assign cell_out0[gi] = (cell_out0_sel[gi] == OUT_FROM_REG) ? q_eff[gi] : lut_res[gi];
      assign cell_out1[gi] = (cell_out1_sel[gi] == OUT_FROM_REG) ? q_eff[gi] : lut_res[gi];


      // Register path checks
      reg_hold_a: assert property (!tick && !force_on |=> q[gi] == $past(q[gi]))
        else $error("cell register changed without its enable");
      reg_capture_a: assert property (tick && !force_on && !cluster_sync_clear[K]
                                      |=> q[gi] == $past(lut_res[gi]))
        else $error("cell register missed table result");
      out_packing_a: assert property (cell_out0_sel[gi] != cell_out1_sel[gi]
                                      |-> (cell_out0[gi] ^ cell_out1[gi]) == (q_eff[gi] ^ lut_res[gi]))
        else $error("cell outputs not independently selected");
      reg_and_comb_a: assert property (cell_out0_sel[gi] == OUT_FROM_LUT &&
                                       cell_out1_sel[gi] == OUT_FROM_REG && tick && !force_on &&
                                       !cluster_sync_clear[K] |=> cell_out1[gi] == $past(cell_out0[gi]))
        else $error("registered copy does not follow table output");
      sync_clear_a: assert property (tick && !force_on && cluster_sync_clear[K] |=> q[gi] == Q_RESET)
        else $error("sync clear did not zero register");

      // Arithmetic checks
      carry_zero_a: assert property (!cell_arith_mode[gi] |-> !cout[gi])
        else $error("carry driven outside arithmetic mode");
      adder_sum_a: assert property (cell_arith_mode[gi] && mask == ADDER_MASK &&
                                    cmode == CASC_NONE |-> lut_res[gi] == (din[0] ^ din[1] ^ cin[gi]))
        else $error("adder sum wrong");
      adder_carry_a: assert property (cell_arith_mode[gi] && mask == ADDER_MASK
        |-> cout[gi] == ((din[0] & din[1]) | (cin[gi] & (din[0] ^ din[1]))))
        else $error("adder carry wrong");
      carry_tail_a: assert property (cell_arith_mode[gi] && mask == ADDER_MASK &&
                                     din[1:0] == 2'h0 && cmode == CASC_NONE |-> lut_res[gi] == cin[gi])
        else $error("extra cell does not expose final carry");

      // Cluster line and cascade checks
      line_force_a: assert property (force_on |-> q_eff[gi] == force_val ##1 q[gi] == $past(force_val))
        else $error("cluster line did not force register");
      line_off_a: assert property (cluster_clear_a[K] && cluster_clear_a_mode[K*2 +: 2] == LINE_OFF &&
                                   !cluster_clear_b[K] |-> !force_on)
        else $error("line in off role still forced register");
      cascade_and_a: assert property (cmode == CASC_AND && !casc_in[gi] |-> !lut_res[gi])
        else $error("cascade and not applied");
      cascade_or_a: assert property (cmode == CASC_OR && casc_in[gi] |-> lut_res[gi])
        else $error("cascade or not applied");

      // Chain link checks
      if (J != 0) begin : g_link_chk
        carry_link_a: assert property (cout[gi-1] |-> cin[gi])
          else $error("carry not passed to next cell");
        casc_link_a: assert property (casc_in[gi] == lut_res[gi-1])
          else $error("cascade not passed to next cell");
      end else if (K >= CHAIN_SKIP) begin : g_skip_chk
        carry_skip_a: assert property (cin[gi] == cout[gi-CPC-1])
          else $error("carry skip to alternate cluster broken");
        casc_skip_a: assert property (casc_in[gi] == lut_res[gi-CPC-1])
          else $error("cascade skip to alternate cluster broken");
      end
    end
  endgenerate

  // Cell registers; cluster lines reach them through next_q
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Final carry and cascade of each interleaved chain leave from that chain's last cluster
  // Even chain ends in the highest even cluster, odd chain in the highest odd one
  assign chain_carry_out[0]   = cout[(CLUSTERS - 2 + (CLUSTERS % 2)) * CPC + CPC - 1];
  assign chain_carry_out[1]   = cout[(CLUSTERS - 1 - (CLUSTERS % 2)) * CPC + CPC - 1];
  assign chain_cascade_out[0] = lut_res[(CLUSTERS - 2 + (CLUSTERS % 2)) * CPC + CPC - 1];
  assign chain_cascade_out[1] = lut_res[(CLUSTERS - 1 - (CLUSTERS % 2)) * CPC + CPC - 1];

  // Main scenarios: ripple, packing, preset, sync clear, cascade
  cov_ripple_c: cover property (chain_carry_in[0] && cin[CPC] ##1 cout[N-1]);
  cov_packing_c: cover property (cell_out0_sel[0] != cell_out1_sel[0] && cell_out0[0] != cell_out1[0]);
  cov_preset_c: cover property (cluster_clear_a[0] && cluster_clear_a_mode[1:0] == LINE_PRESET);
  cov_sclr_c: cover property (cluster_sync_clear[0] && cluster_clock_tick_a[0] && cluster_clock_enable_a[0]);
  cov_cascade_c: cover property (cell_cascade_mode[1:0] == CASC_AND && lut_res[0]);

endmodule : lccc_cluster_group

// [verilog/lccc_pkg.sv]
// Constants for the logic cell cluster with carry and cascade chains
package lccc_pkg;
  localparam int CELLS_PER_CLUSTER = 10;
  localparam int CLUSTERS_DEF      = 4;
  localparam int CHAIN_SKIP        = 2;
  localparam int LUT_INPUTS        = 4;
  localparam int LUT_BITS          = 16;
  localparam int ARITH_HALF        = 8;

  localparam logic [LUT_BITS-1:0] ADDER_MASK = 16'he896;

  localparam logic [1:0] CASC_NONE = 2'h0;
  localparam logic [1:0] CASC_AND  = 2'h1;
  localparam logic [1:0] CASC_OR   = 2'h2;

  localparam logic [1:0] LINE_CLEAR  = 2'h0;
  localparam logic [1:0] LINE_PRESET = 2'h1;
  localparam logic [1:0] LINE_LOAD   = 2'h2;
  localparam logic [1:0] LINE_OFF    = 2'h3;

  localparam logic OUT_FROM_LUT = 1'b0;
  localparam logic OUT_FROM_REG = 1'b1;
  localparam logic CLK_PAIR_A   = 1'b0;
  localparam logic CLK_PAIR_B   = 1'b1;
  localparam logic Q_RESET      = 1'b0;
endpackage : lccc_pkg
